/* verilog/capture_pkg.sv */
// Behaviour
// - Free-running counter wraps from top to zero.
// - Each capture pushes present counter value unless FIFO full and not read.
// - Sync mode: sync event clears the counter.
// - Trigger mode: counter held until trigger.
// - Source zero and no trigger: free-running.
// - Source zero with trigger: software sets status.
// - Cascade: odd low word, wrap bumps even.
// - Falling, rising, both, 4th, 16th rising edges.
// - Interrupt on every or several captures.
// - Captured values kept in four-deep FIFO.
// - Not-empty flag follows unread FIFO contents.
// - Cascaded even module follows the odd one.
// - Odd module settings govern the pair.
// - Cascaded sync pair held until sync arrives.
// - Odd buffer low word, even buffer high.
// - Six time bases, thirty sync sources.
// - Capture-mode field encodes eight settings.
// - Captures per interrupt 1..4, ignored both-edge.
// - Read-only overflow flag reports lost capture.
package capture_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int        ADDR_W      = 12;
  localparam logic [11:0] ADDR_CON1 = 12'h000;
  localparam logic [11:0] ADDR_CON2 = 12'h004;
  localparam logic [11:0] ADDR_BUF  = 12'h008;
  localparam logic [11:0] ADDR_CNT  = 12'h00c;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int TSEL_LO = 10;
  localparam int ICI_LO  = 5;
  localparam int OV_BIT  = 4;
  localparam int BNE_BIT = 3;
  localparam int ICM_LO  = 0;
  localparam int CASCADE_ENABLE_BIT = 8;
  localparam int TRIG_BIT = 7;
  localparam int TSTAT_BIT = 6;
  localparam int SSEL_LO  = 0;

  // ----------------------------------------------------------------
  // Reset values and widths
  // ----------------------------------------------------------------
  localparam logic [4:0]  SSEL_RESET = 5'h0d;
  localparam logic [4:0]  SSEL_NONE  = 5'h00;
  localparam logic [2:0]  TSEL_RESET = 3'h0;
  localparam int          NUM_TB     = 6;
  localparam int          NUM_SYNC   = 30;
  localparam logic [15:0] CNT_TOP    = 16'hffff;
  localparam logic [15:0] CNT_ZERO   = 16'h0000;
  localparam logic [3:0]  PRE4_LAST  = 4'h3;
  localparam logic [3:0]  PRE16_LAST = 4'hf;

  // ----------------------------------------------------------------
  // Capture modes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_OFF    = 3'b000,
    MODE_BOTH   = 3'b001,
    MODE_FALL   = 3'b010,
    MODE_RISE   = 3'b011,
    MODE_RISE4  = 3'b100,
    MODE_RISE16 = 3'b101,
    MODE_UNUSED = 3'b110,
    MODE_WAKE   = 3'b111
  } capture_mode_t;

endpackage : capture_pkg

/* verilog/capture_fifo_mem.sv */
`timescale 1ns/1ps
module capture_fifo_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4,
  parameter int AW    = 2
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data_q
);

  logic [WIDTH-1:0] mem [DEPTH];

  // Storage write, no reset needed for data
  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Registered read of the head entry
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rd_data_q <= '0;
    end else begin
      rd_data_q <= mem[rd_addr];
    end
  end

endmodule : capture_fifo_mem

/* verilog/capture_edge.sv */
`timescale 1ns/1ps
module capture_edge
  import capture_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       capture_input_pin,
  input  wire logic [2:0] mode,
  output logic            capture_pulse,
  output logic            wake_pulse
);

  logic       sync1_q;
  logic       sync2_q;
  logic       prev_q;
  logic [3:0] pre_q;
  logic [3:0] pre_d;

  // Two-stage synchroniser; only sync2 is examined
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q  <= 1'b0;
      pre_q   <= '0;
    end else begin
      sync1_q <= capture_input_pin;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
      pre_q   <= pre_d;
    end
  end

  wire rise = sync2_q & ~prev_q;
  wire fall = ~sync2_q & prev_q;
  wire pre_mode = (mode == MODE_RISE4) || (mode == MODE_RISE16);
  wire [3:0] pre_last = (mode == MODE_RISE16) ? PRE16_LAST : PRE4_LAST;
  wire pre_hit = rise && (pre_q == pre_last);

  // Prescaler restarts whenever it is not in use
  assign pre_d = !pre_mode ? '0 : pre_hit ? '0 : rise ? pre_q + 4'h1 : pre_q;

  // Edge qualification per mode
  assign capture_pulse = (mode == MODE_BOTH && (rise || fall)) ||
                         (mode == MODE_FALL && fall) ||
                         (mode == MODE_RISE && rise) ||
                         (pre_mode && pre_hit);
  assign wake_pulse = (mode == MODE_WAKE) && rise;

endmodule : capture_edge

/* verilog/capture_timer.sv */
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/1ps
module capture_timer
  import capture_pkg::*;
#(
  parameter bit IS_ODD = 1'b1,
  parameter int DEPTH  = 4,
  parameter int CNT_W  = 16
) (
  input  wire logic                core_clk,
  input  wire logic                rst,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [ADDR_W-1:0]   paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata_q,
  output logic                     pready_q,
  output logic                     pslverr_q,
  input  wire logic                capture_input_pin,
  input  wire logic [NUM_TB-1:0]   timebase_tick,
  input  wire logic [NUM_SYNC-1:0] sync_event,
  input  wire logic                casc_wrap_in,
  input  wire logic                casc_capture_in,
  input  wire logic                casc_clear_in,
  output logic                     casc_wrap_q,
  output logic                     casc_capture_q,
  output logic                     casc_clear_q,
  output logic                     capture_irq_q
);

  localparam int AW = $clog2(DEPTH);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic tick_pick(input logic [2:0] sel, input logic [NUM_TB-1:0] t);
    logic r;
    r = 1'b0;
    case (sel)
      3'b000:  r = t[0];
      3'b001:  r = t[1];
      3'b010:  r = t[2];
      3'b011:  r = t[3];
      3'b100:  r = t[4];
      3'b111:  r = t[5];
      default: r = 1'b0;
    endcase
    return r;
  endfunction : tick_pick

  function automatic logic sync_pick(input logic [4:0] sel, input logic [NUM_SYNC-1:0] s);
    logic r;
    r = 1'b0;
    if (sel != SSEL_NONE && int'(sel) <= NUM_SYNC) begin
      r = s[int'(sel) - 1];
    end
    return r;
  endfunction : sync_pick

  // ----------------------------------------------------------------
  // Control state
  // ----------------------------------------------------------------
  logic [2:0]       tsel_q;
  logic [1:0]       ici_q;
  logic [2:0]       icm_q;
  logic             ov_q;
  logic             cascade_enable_q;
  logic             trig_q;
  logic             tstat_q;
  logic [4:0]       ssel_q;
  logic             armed_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [1:0]       icnt_q;
  logic [1:0]       icnt_d;
  logic [AW:0]      wr_ptr_q;
  logic [AW:0]      rd_ptr_q;
  logic [CNT_W-1:0] head_data;
  logic [31:0]      rd_mux;
  logic             addr_ok;
  logic             local_cap;
  logic             fifo_empty;
  logic             wake_ev;

  // ----------------------------------------------------------------
  // APB decode; one wait state on every access
  // ----------------------------------------------------------------
  wire access   = psel && penable;
  wire first    = access && !pready_q;
  wire done     = access && pready_q;
  wire wr_con1  = done && pwrite && (paddr == ADDR_CON1);
  wire wr_con2  = done && pwrite && (paddr == ADDR_CON2);
  wire rd_buf   = done && !pwrite && (paddr == ADDR_BUF);

  // Read mux and address check
  always_comb begin
    rd_mux  = '0;
    addr_ok = 1'b1;
    if (paddr == ADDR_CON1) begin
      rd_mux[TSEL_LO+2:TSEL_LO] = tsel_q;
      rd_mux[ICI_LO+1:ICI_LO]   = ici_q;
      rd_mux[OV_BIT]            = ov_q;
      rd_mux[BNE_BIT]           = !fifo_empty;
      rd_mux[ICM_LO+2:ICM_LO]   = icm_q;
    end else if (paddr == ADDR_CON2) begin
      rd_mux[CASCADE_ENABLE_BIT]          = cascade_enable_q;
      rd_mux[TRIG_BIT]          = trig_q;
      rd_mux[TSTAT_BIT]         = tstat_q;
      rd_mux[SSEL_LO+4:SSEL_LO] = ssel_q;
    end else if (paddr == ADDR_BUF) begin
      rd_mux[CNT_W-1:0] = head_data;
    end else if (paddr == ADDR_CNT) begin
      rd_mux[CNT_W-1:0] = cnt_q;
    end else begin
      addr_ok = 1'b0;
    end
  end

  // Bus answer registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pready_q  <= 1'b0;
      prdata_q  <= '0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= first;
      prdata_q  <= first ? rd_mux : prdata_q;
      pslverr_q <= first && !addr_ok;
    end
  end

  // ----------------------------------------------------------------
  // Operating mode
  // ----------------------------------------------------------------
  // The even half of a pair ignores its own trigger/sync settings
  wire slave     = cascade_enable_q && !IS_ODD;
  wire tick      = tick_pick(tsel_q, timebase_tick);
  wire sync_ev   = sync_pick(ssel_q, sync_event);
  wire sync_mode = (ssel_q != SSEL_NONE) && !trig_q;
  wire held      = trig_q && !tstat_q;
  wire casc_wait = cascade_enable_q && sync_mode && !armed_q;
  wire own_clr   = held || (sync_mode && sync_ev) || casc_wait;
  wire clr       = slave ? casc_clear_in : own_clr;
  wire inc       = (slave ? casc_wrap_in : tick) && !clr;
  wire wrap      = inc && (cnt_q == CNT_TOP);

  // Counter next value
  assign cnt_d = clr ? CNT_ZERO : inc ? cnt_q + 16'h0001 : cnt_q;

  // Trigger, arm and counter state
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_q   <= CNT_ZERO;
      tstat_q <= 1'b0;
      armed_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      // Hardware set wins over a software write
      if (trig_q && (ssel_q != SSEL_NONE) && sync_ev) begin
        tstat_q <= 1'b1;
      end else if (wr_con2) begin
        tstat_q <= pwdata[TSTAT_BIT];
      end
      if (sync_ev) begin
        armed_q <= 1'b1;
      end else if (wr_con2) begin
        armed_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tsel_q <= TSEL_RESET;
      ici_q  <= '0;
      icm_q  <= MODE_OFF;
      cascade_enable_q <= 1'b0;
      trig_q <= 1'b0;
      ssel_q <= SSEL_RESET;
    end else begin
      if (wr_con1) begin
        tsel_q <= pwdata[TSEL_LO+2:TSEL_LO];
        ici_q  <= pwdata[ICI_LO+1:ICI_LO];
        icm_q  <= pwdata[ICM_LO+2:ICM_LO];
      end
      if (wr_con2) begin
        cascade_enable_q <= pwdata[CASCADE_ENABLE_BIT];
        trig_q <= pwdata[TRIG_BIT];
        ssel_q <= pwdata[SSEL_LO+4:SSEL_LO];
      end
    end
  end

  // ----------------------------------------------------------------
  // Capture events
  // ----------------------------------------------------------------
  capture_edge u_edge (
    .core_clk          (core_clk),
    .rst               (rst),
    .capture_input_pin (capture_input_pin),
    .mode              (icm_q),
    .capture_pulse     (local_cap),
    .wake_pulse        (wake_ev)
  );

  // Held counter blocks captures; the even half captures with the odd one
  wire cap_ev = slave ? casc_capture_in : (local_cap && !held);

  // ----------------------------------------------------------------
  // FIFO pointers and storage
  // ----------------------------------------------------------------
  wire [AW:0] fill       = wr_ptr_q - rd_ptr_q;
  assign      fifo_empty = (fill == '0);
  wire        fifo_full  = (fill == (AW+1)'(DEPTH));
  wire        pop        = rd_buf && !fifo_empty;
  wire        push       = cap_ev && (!fifo_full || pop);
  wire        lost       = cap_ev && fifo_full && !pop;

  capture_fifo_mem #(
    .WIDTH (CNT_W),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_mem (
    .core_clk  (core_clk),
    .rst       (rst),
    .wr_en     (push),
    .wr_addr   (wr_ptr_q[AW-1:0]),
    .wr_data   (cnt_q),
    .rd_addr   (rd_ptr_q[AW-1:0]),
    .rd_data_q (head_data)
  );

  // Pointers and overflow; a read in the same cycle makes room, so no overflow is set
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      ov_q     <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      if (lost) begin
        ov_q <= 1'b1;
      end else if (pop) begin
        ov_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt pacing
  // ----------------------------------------------------------------
  // Both-edge mode interrupts on every capture and ignores the count
  wire every   = (icm_q == MODE_BOTH);
  wire cnt_hit = cap_ev && (every || icnt_q == ici_q);
  wire mode_on = (icm_q != MODE_OFF) && (icm_q != MODE_UNUSED);

  assign icnt_d = !mode_on ? '0 : cnt_hit ? '0 : cap_ev ? icnt_q + 2'h1 : icnt_q;

  // Interrupt and cascade outputs
  always_ff @(posedge core_clk) begin
    if (rst) begin
      icnt_q         <= '0;
      capture_irq_q  <= 1'b0;
      casc_wrap_q    <= 1'b0;
      casc_capture_q <= 1'b0;
      casc_clear_q   <= 1'b0;
    end else begin
      icnt_q         <= icnt_d;
      capture_irq_q  <= !slave && (cnt_hit || wake_ev);
      casc_wrap_q    <= wrap;
      casc_capture_q <= cap_ev;
      casc_clear_q   <= clr;
    end
  end

endmodule : capture_timer

/* test/capture_timer_props.sv */
`timescale 1ns/1ps
module capture_timer_props
  import capture_pkg::*;
(
  input wire logic              core_clk,
  input wire logic              rst,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata_q,
  input wire logic              pready_q,
  input wire logic              pslverr_q,
  input wire logic              casc_wrap_q,
  input wire logic              casc_capture_q,
  input wire logic              capture_irq_q
);
  // ------
  // Helpers
  // ------
  logic [2:0] mode_q;
  logic       mapped;
  logic       done;

  // Completed transfer and decoded offset
  assign mapped = paddr inside {ADDR_CON1, ADDR_CON2, ADDR_BUF, ADDR_CNT};
  assign done   = psel && penable && pready_q;

  // Mode shadow: wake mode pulses the irq with no capture behind it
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mode_q <= 3'h0;
    end else if (done && pwrite && paddr == ADDR_CON1) begin
      mode_q <= pwdata[2:0];
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // ------
  // Properties
  // ------
  a_one_wait: assert property (psel && penable && !pready_q |=> pready_q)
    else $error("ready missing after one wait state");
  a_ready_once: assert property (pready_q |=> !pready_q)
    else $error("ready held beyond one cycle");
  a_ready_access: assert property (pready_q |-> psel && penable)
    else $error("ready outside an access phase");
  a_unmapped_err: assert property (done && !mapped && !pwrite |-> pslverr_q && prdata_q == 32'h0)
    else $error("unmapped read not refused");
  a_mapped_ok: assert property (done && mapped |-> !pslverr_q)
    else $error("mapped access refused");
  a_upper_zero: assert property (done && !pwrite |-> prdata_q[31:16] == 16'h0)
    else $error("upper read half not zero");
  a_irq_capture: assert property (capture_irq_q && mode_q != MODE_WAKE |-> casc_capture_q)
    else $error("irq without capture");
  a_wrap_single: assert property (casc_wrap_q |=> !casc_wrap_q)
    else $error("wrap pulse too long");
  a_reset_quiet: assert property ($fell(rst) |-> !pready_q && !capture_irq_q && !casc_capture_q)
    else $error("output active after reset");
endmodule : capture_timer_props

bind capture_timer capture_timer_props u_props (
  .core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata_q,
  .pready_q, .pslverr_q, .casc_wrap_q, .casc_capture_q, .capture_irq_q
);

/* test/pin_source.sv */
`timescale 1ns/1ps
module pin_source (
  input wire logic       core_clk,
  input wire logic       go,
  input wire logic [7:0] num,
  output logic           pin,
  output logic           busy
);
  logic [7:0] left_q;
  logic [1:0] div_q;

  // Toggle every third cycle so the synchroniser sees each level
  initial begin
    pin    = 1'b0;
    left_q = 8'h00;
    div_q  = 2'h0;
  end
  always @(posedge core_clk) begin
    if (go) begin
      left_q <= num;
    end else if (left_q != 8'h00) begin
      div_q <= div_q + 2'h1;
      if (div_q == 2'h2) begin
        pin    <= ~pin;
        left_q <= left_q - 8'h01;
        div_q  <= 2'h0;
      end
    end
  end
  assign busy = go || left_q != 8'h00;
endmodule : pin_source

/* test/input_capture_dedicated_timer_bench.sv */
`timescale 1ns/1ps
module input_capture_dedicated_timer_bench
  import capture_pkg::*;
;
  typedef struct {
    logic [2:0]  tsel;
    logic [5:0]  tick;
    logic [2:0]  mode;
    logic [7:0]  tr;
    logic [15:0] cnt;
    int          cap;
    int          irq;
  } row_t;
  row_t        rows [9];
  logic        core_clk, rst, psel, penable, pwrite, go, pin, busy;
  logic        pready_q, pslverr_q, capture_irq_q, rerr, clr_q;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata_q, rdata;
  logic [5:0]  tick;
  logic [29:0] sync;
  logic [7:0]  num;
  int          num_errors, checks_done, irqs;

  capture_timer DUT (
    .core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata_q,
    .pready_q, .pslverr_q, .capture_input_pin(pin), .timebase_tick(tick),
    .sync_event(sync), .casc_wrap_in(1'b0), .casc_capture_in(1'b0),
    .casc_clear_in(1'b0), .casc_wrap_q(), .casc_capture_q(), .casc_clear_q(clr_q),
    .capture_irq_q
  );
  pin_source src (.core_clk, .go, .num, .pin, .busy);

  // ------
  // Tasks
  // ------
  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Request held until ready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready_q !== 1'b1 && n < 16);
    chk({31'h0, pready_q}, 32'h1);
    rdata = prdata_q;
    rerr  = pslverr_q;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdata, exp);
  endtask : rd

  // One-cycle pulses with a low cycle between them
  task automatic drive(input logic [5:0] t, input logic [29:0] s, input int k);
    repeat (k) begin
      @(posedge core_clk);
      tick <= t;
      sync <= s;
      @(posedge core_clk);
      tick <= 6'h00;
      sync <= 30'h0;
    end
  endtask : drive

  // Wait covers sync, edge detect, push and irq
  task automatic pins(input logic [7:0] n);
    int k;
    k = 0;
    @(posedge core_clk);
    go  <= 1'b1;
    num <= n;
    @(posedge core_clk);
    go <= 1'b0;
    while (busy === 1'b1 && k < 400) begin
      @(posedge core_clk);
      k++;
    end
    repeat (6) @(posedge core_clk);
  endtask : pins

  task automatic drain(input int n, input logic [15:0] v, input logic [15:0] s);
    int k;
    k = 0;
    apb(1'b0, ADDR_CON1, 32'h0);
    while (rdata[BNE_BIT] === 1'b1 && k < 6) begin
      apb(1'b0, ADDR_BUF, 32'h0);
      chk(rdata, {16'h0, v});
      v = v + s;
      k++;
      apb(1'b0, ADDR_CON1, 32'h0);
    end
    chk(k, n);
  endtask : drain

  // ------
  // Stimulus
  // ------
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (capture_irq_q === 1'b1) begin
      irqs++;
    end
  end
  initial begin
    repeat (90000) @(posedge core_clk);
    num_errors++;
    close_out();
  end

  initial begin
    rows[0] = '{3'h0, 6'h01, 3'h3, 8'd2, 16'h1, 1, 1};
    rows[1] = '{3'h1, 6'h02, 3'h1, 8'd4, 16'h2, 4, 4};
    rows[2] = '{3'h2, 6'h04, 3'h2, 8'd6, 16'h3, 3, 3};
    rows[3] = '{3'h3, 6'h08, 3'h4, 8'd16, 16'h4, 2, 2};
    rows[4] = '{3'h4, 6'h10, 3'h5, 8'd64, 16'h5, 2, 2};
    rows[5] = '{3'h5, 6'h3f, 3'h3, 8'd2, 16'h0, 1, 1};
    rows[6] = '{3'h6, 6'h3f, 3'h0, 8'd4, 16'h0, 0, 0};
    rows[7] = '{3'h7, 6'h20, 3'h6, 8'd4, 16'h0, 0, 0};
    rows[8] = '{3'h7, 6'h20, 3'h7, 8'd4, 16'h0, 0, 2};
    {rst, psel, penable, pwrite, go, paddr, pwdata, tick, sync, num} = '0;
    rst = 1'b1;
    num_errors = 0;
    checks_done = 0;
    irqs = 0;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    rd(ADDR_CON1, 32'h0);
    rd(ADDR_CON2, {27'h0, SSEL_RESET});
    rd(ADDR_CNT, 32'h0);
    apb(1'b1, 12'h010, 32'h1);
    chk({31'h0, rerr}, 32'h1);
    rd(12'h010, 32'h0);
    // Sync mode clears the count before each row
    apb(1'b1, ADDR_CON2, 32'h1);
    foreach (rows[i]) begin
      apb(1'b1, ADDR_CON1, {19'h0, rows[i].tsel, 7'h0, rows[i].mode});
      drive(6'h00, 30'h1, 1);
      drive(rows[i].tick, 30'h0, i + 1);
      if (rows[i].cap != 0) rd(ADDR_CNT, {16'h0, rows[i].cnt});
      irqs = 0;
      pins(rows[i].tr);
      drain(rows[i].cap, rows[i].cnt, 16'h0);
      chk(irqs, rows[i].irq);
      apb(1'b1, ADDR_CON1, 32'h0);
    end
    // Fifth capture into a full buffer is lost
    apb(1'b1, ADDR_CON1, 32'h1c63);
    drive(6'h00, 30'h1, 1);
    irqs = 0;
    repeat (5) begin
      drive(6'h20, 30'h0, 1);
      pins(8'd2);
    end
    chk(irqs, 1);
    rd(ADDR_CON1, 32'h1c7b);
    drain(4, 16'h1, 16'h1);
    rd(ADDR_CON1, 32'h1c63);
    apb(1'b1, ADDR_CON2, 32'h81);
    drive(6'h20, 30'h0, 3);
    rd(ADDR_CNT, 32'h0);
    chk({31'h0, clr_q}, 32'h1);
    pins(8'd2);
    drain(0, 16'h0, 16'h0);
    drive(6'h00, 30'h1, 1);
    rd(ADDR_CON2, 32'hc1);
    drive(6'h20, 30'h0, 2);
    rd(ADDR_CNT, 32'h2);
    apb(1'b1, ADDR_CON2, 32'h80);
    drive(6'h20, 30'h0, 2);
    rd(ADDR_CNT, 32'h0);
    apb(1'b1, ADDR_CON2, 32'hc0);
    drive(6'h20, 30'h0, 3);
    rd(ADDR_CNT, 32'h3);
    // Cascaded sync pair stays cleared until the first sync event
    apb(1'b1, ADDR_CON2, 32'h101);
    drive(6'h20, 30'h0, 2);
    rd(ADDR_CNT, 32'h0);
    chk({31'h0, clr_q}, 32'h1);
    drive(6'h00, 30'h1, 1);
    drive(6'h20, 30'h0, 2);
    rd(ADDR_CNT, 32'h2);
    apb(1'b1, ADDR_CON2, 32'h1);
    drive(6'h00, 30'h1, 1);
    apb(1'b1, ADDR_CON2, 32'h0);
    @(posedge core_clk);
    tick <= 6'h20;
    repeat (65535) @(posedge core_clk);
    tick <= 6'h00;
    drive(6'h00, 30'h1, 1);
    rd(ADDR_CNT, 32'hffff);
    drive(6'h20, 30'h0, 1);
    rd(ADDR_CNT, 32'h0);
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    rd(ADDR_CON2, {27'h0, SSEL_RESET});
    rd(ADDR_CON1, 32'h0);
    close_out();
  end
endmodule : input_capture_dedicated_timer_bench
